// >>> bench/cps_timer_model.sv
// timer counters and sensing oscillator on the far side of the block
`timescale 1ns/1ps
module cps_timer_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// bench control
	input  wire logic        clear_in,
	input  wire logic [3:0]  half_in,
	// count strobes from the block
	input  wire logic        t8_in,
	input  wire logic        t16_in,
	// oscillator phase and counts
	output logic             osc_out,
	output logic      [7:0]  t8_out,
	output logic      [15:0] t16_out
);
	logic [3:0] div_r;

	// oscillator runs freely: gating it is the block's job, not ours
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_r   <= 4'h0;
			osc_out <= 1'b0;
			t8_out  <= 8'h00;
			t16_out <= 16'h0000;
		end else begin
			div_r <= (div_r + 4'h1 >= half_in) ? 4'h0 : div_r + 4'h1;
			if (div_r + 4'h1 >= half_in)
				osc_out <= ~osc_out;
			t8_out  <= clear_in ? 8'h00 : t8_out + {7'h00, t8_in};
			t16_out <= clear_in ? 16'h0000 : t16_out + {15'h0000, t16_in};
		end
	end
endmodule // cps_timer_model

// >>> bench/tb_top.sv
// self-checking bench for the capacitive sensing control block
`timescale 1ns/1ps
module tb_top;
	import cps_pkg::*;
	localparam logic [31:0] A_CTRL = 32'(CPS_OFF_CTRL);
	localparam logic [31:0] A_CHAN = 32'(CPS_OFF_CHAN);
	localparam logic [31:0] A_TCFG = 32'(CPS_OFF_TMRCFG);
	localparam logic [31:0] A_STAT = 32'(CPS_OFF_STATUS);
	localparam int          W      = 240;
	logic        clk_in, rst_in, hsel, hwrite, man, man_v, pin, gate, sleep;
	logic        clr, osc, t8c, t16c, en_o, rdy, tog, tgate;
	logic [31:0] hrd_s, rd_s;
	logic [15:0] pads_s;
	logic [1:0]  htrans, rng_o, resp;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] pads, c16, nom, lod, thr;
	logic [7:0]  c8;
	logic [3:0]  half, pc;
	int          n_mismatch, checks;
	logic [7:0]  tc_ct [10] = '{8'h8C, 8'h8D, 8'h8D, 8'h8C, 8'h8D, 8'h8D, 8'h8D, 8'h8D, 8'h0D, 8'h81};
	logic [7:0]  tc_tc [10] = '{8'h0E, 8'h0E, 8'h0F, 8'h0F, 8'h07, 8'h1F, 8'h1F, 8'h0F, 8'h0F, 8'h0F};
	int          tc_e8 [10] = '{60, 60, 20, 12, 20, 20, 20, 0, 0, 0};
	int          tc_e16 [10] = '{20, 20, 20, 20, 0, 0, 20, 20, 0, 0};

	always #25 clk_in = ~clk_in;

	// external clock pin: period of 20 cycles, distinct from the oscillator
	always @(posedge clk_in) begin
		pc <= (pc == 4'h9) ? 4'h0 : pc + 4'h1;
		if (pc == 4'h9)
			pin <= ~pin;
	end

	// 8-bit overflow toggles the gate, forming the 16-bit window
	always @(posedge clk_in) begin
		if (!tog)
			tgate <= 1'b0;
		else if (c8 == 8'hFF && t8c)
			tgate <= ~tgate;
	end

	cps_sense_ctrl #(.SMALL_PKG(1'b0)) DUT (
		.clk_in                  (clk_in),
		.rst_in                  (rst_in),
		.hsel_in                 (hsel),
		.haddr_in                (haddr),
		.htrans_in               (htrans),
		.hwrite_in               (hwrite),
		.hsize_in                (hsize),
		.hwdata_in               (hwdata),
		.hready_in               (rdy),
		.hrdata_out              (hrdata),
		.hreadyout_out           (rdy),
		.hresp_out               (resp),
		.osc_phase_in            (man ? man_v : osc),
		.timer8_ext_clock_pin_in (pin),
		.timer16_gate_in         (tog ? tgate : gate),
		.sleep_in                (sleep),
		.sense_enable_out        (en_o),
		.osc_range_out           (rng_o),
		.sense_pad_n_out         (pads),
		.timer8_count_out        (t8c),
		.timer16_count_out       (t16c)
	);

	// small variant on the same bus, watched for the missing upper pads
	cps_sense_ctrl #(.SMALL_PKG(1'b1)) DUT_S (
		.clk_in                  (clk_in),
		.rst_in                  (rst_in),
		.hsel_in                 (hsel),
		.haddr_in                (haddr),
		.htrans_in               (htrans),
		.hwrite_in               (hwrite),
		.hsize_in                (hsize),
		.hwdata_in               (hwdata),
		.hready_in               (rdy),
		.hrdata_out              (hrd_s),
		.hreadyout_out           (),
		.hresp_out               (),
		.osc_phase_in            (man ? man_v : osc),
		.timer8_ext_clock_pin_in (pin),
		.timer16_gate_in         (tog ? tgate : gate),
		.sleep_in                (sleep),
		.sense_enable_out        (),
		.osc_range_out           (),
		.sense_pad_n_out         (pads_s),
		.timer8_count_out        (),
		.timer16_count_out       ()
	);

	cps_timer_model partner (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.clear_in (clr),
		.half_in  (half),
		.t8_in    (t8c),
		.t16_in   (t16c),
		.osc_out  (osc),
		.t8_out   (c8),
		.t16_out  (c16)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// counts depend on oscillator phase at window edges, so allow one either way
	task automatic near(input logic [15:0] got, input int exp);
		logic ok;
		ok = (got <= exp + 1) && (got + 1 >= exp);
		if (ok === 1'b1)
			chk({16'h0, got}, {16'h0, got});
		else
			chk({16'h0, got}, 32'(exp));
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clk_in); while (rdy !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (rdy !== 1'b1);
		rd = hrdata;
		rd_s = hrd_s;
	endtask

	task automatic meas(input logic [7:0] ct, input logic [7:0] tc, input logic g, input logic s);
		xfer(1'b1, A_CTRL, {24'h0, ct});
		xfer(1'b1, A_TCFG, {24'h0, tc});
		gate  <= g;
		sleep <= s;
		tick(12);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(W);
	endtask

	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		end_sim();
	end

	initial begin
		{clk_in, hsel, hwrite, man, man_v, pin, gate, sleep, clr, tog, tgate} = '0;
		{htrans, haddr, hwdata, pc, n_mismatch, checks} = '0;
		hsize  = CPS_HSIZE_WORD;
		half   = 4'h6;
		rst_in = 1'b1;
		tick(20);
		rst_in <= 1'b0;
		xfer(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'(CPS_CTRL_RST));
		xfer(1'b0, A_CHAN, 32'h0);
		chk(rd, 32'(CPS_CHAN_RST));
		xfer(1'b0, A_TCFG, 32'h0);
		chk(rd, 32'(CPS_TCFG_RST));
		xfer(1'b0, 32'h10, 32'h0);
		chk(rd, 32'h0);
		chk({30'h0, resp}, {30'h0, CPS_HRESP_OKAY});
		xfer(1'b1, A_CTRL, 32'hFF);
		xfer(1'b0, A_CTRL, 32'h0);
		chk(rd & ~32'h2, 32'h8D);
		for (int ch = 0; ch < 16; ch++) begin
			xfer(1'b1, A_CHAN, 32'(ch));
			xfer(1'b0, A_CHAN, 32'h0);
			chk(rd, 32'(ch));
			chk({16'h0, pads}, 32'h1 << ch);
			chk(rd_s, 32'(ch) & 32'h7);
			chk({16'h0, pads_s}, (ch < 8) ? (32'h1 << ch) : 32'h0);
		end
		xfer(1'b1, A_CTRL, 32'h0C);
		xfer(1'b0, A_CHAN, 32'h0);
		chk({16'h0, pads}, 32'h0);
		chk({29'h0, en_o, rng_o}, 32'h0);
		for (int r = 0; r < 4; r++) begin
			xfer(1'b1, A_CTRL, 32'h80 | 32'(r << 2));
			tick(2);
			chk({29'h0, en_o, rng_o}, 32'h4 | 32'(r));
		end
		for (int v = 0; v < 2; v++) begin
			man   <= 1'b1;
			man_v <= v[0];
			tick(8);
			xfer(1'b0, A_CTRL, 32'h0);
			chk({31'h0, rd[CPS_CTRL_PHASE_BIT]}, 32'(v));
			xfer(1'b0, A_STAT, 32'h0);
			chk({31'h0, rd[CPS_STAT_PHASE_BIT]}, 32'(v));
		end
		man <= 1'b0;
		sleep <= 1'b1;
		gate  <= 1'b1;
		tick(4);
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd & 32'h6, 32'h6);
		for (int i = 0; i < 10; i++) begin
			meas(tc_ct[i], tc_tc[i], i == 6, i == 7);
			sleep <= 1'b0;
			gate  <= 1'b0;
			near({8'h0, c8}, tc_e8[i]);
			near(c16, tc_e16[i]);
		end
		meas(8'h8D, 8'h0F, 1'b0, 1'b0);
		nom = c16;
		half <= 4'h8;
		meas(8'h8D, 8'h0F, 1'b0, 1'b0);
		lod = c16;
		near(nom, 20);
		near(lod, 15);
		thr = (nom + lod) / 2;
		chk({31'h0, lod < thr && thr < nom}, 32'h1);
		// window of 256 quarter-clock counts, oscillator period 16 cycles
		tog <= 1'b1;
		meas(8'h8D, 8'h1E, 1'b0, 1'b0);
		tick(2000);
		near(c16, 64);
		end_sim();
	end
endmodule // tb_top

// >>> rtl/cps_osc_if.sv
// carrier between the control core and the oscillator tracker
`timescale 1ns/1ps
interface cps_osc_if;
	logic       enable;
	logic [1:0] range;
	logic       phase;
	logic       tick;

	modport ctrl  (output enable, output range, input phase, input tick);
	modport track (input enable, input range, output phase, output tick);
endinterface

// >>> rtl/cps_osc_track.sv
// synchronises the sensing oscillator phase and makes one count pulse per period
`timescale 1ns/1ps
module cps_osc_track
	import cps_pkg::*;
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// raw oscillator phase from the analogue side
	input  wire logic osc_phase_in,
	// towards the control core
	cps_osc_if.track  osc
);

	logic ph_s1_r, ph_s2_r, ph_s3_r, tick_r;
	logic ph_s1_nxt, ph_s2_nxt, ph_s3_nxt, tick_nxt;
	logic active;

	always_comb begin
		active    = osc.enable && (osc.range != CPS_RNG_OFF);
		ph_s1_nxt = osc_phase_in;
		ph_s2_nxt = ph_s1_r;
		ph_s3_nxt = ph_s2_r;
		// count pulse gated off while sensing is off, so a stray edge gives no count
		tick_nxt  = active && ph_s2_r && !ph_s3_r;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ph_s1_r <= 1'b0;
			ph_s2_r <= 1'b0;
			ph_s3_r <= 1'b0;
			tick_r  <= 1'b0;
		end else begin
			ph_s1_r <= ph_s1_nxt;
			ph_s2_r <= ph_s2_nxt;
			ph_s3_r <= ph_s3_nxt;
			tick_r  <= tick_nxt;
		end
	end

	assign osc.phase = ph_s2_r;
	assign osc.tick  = tick_r;

	osc_static_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(!osc.enable || osc.range == CPS_RNG_OFF) |=> !tick_r)
		else $error("oscillator count while sensing is off");

	tick_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)
		tick_r |-> $past(ph_s2_r) && !$past(ph_s3_r))
		else $error("count pulse without rising phase");

endmodule // cps_osc_track

// >>> rtl/cps_pkg.sv
// shared constants for the capacitive sensing control block
package cps_pkg;

	// register byte offsets on the bus
	localparam logic [3:0]  CPS_OFF_CTRL       = 4'h0;
	localparam logic [3:0]  CPS_OFF_CHAN       = 4'h4;
	localparam logic [3:0]  CPS_OFF_TMRCFG     = 4'h8;
	localparam logic [3:0]  CPS_OFF_STATUS     = 4'hC;

	// control register fields
	localparam int          CPS_CTRL_EN_BIT    = 7;
	localparam int          CPS_CTRL_RNG_LSB   = 2;
	localparam int          CPS_CTRL_PHASE_BIT = 1;
	localparam int          CPS_CTRL_T8XS_BIT  = 0;

	// timer configuration register fields
	localparam int          CPS_TCFG_T8CS_BIT  = 0;
	localparam int          CPS_TCFG_T16CS_LSB = 1;
	localparam int          CPS_TCFG_T16ON_BIT = 3;
	localparam int          CPS_TCFG_T16GE_BIT = 4;

	// status register fields
	localparam int          CPS_STAT_PHASE_BIT = 0;
	localparam int          CPS_STAT_SLEEP_BIT = 1;
	localparam int          CPS_STAT_GATE_BIT  = 2;

	// reset values
	localparam logic [7:0]  CPS_CTRL_RST       = 8'h00;
	localparam logic [3:0]  CPS_CHAN_RST       = 4'h0;
	localparam logic [4:0]  CPS_TCFG_RST       = 5'h00;

	// oscillator range codes
	localparam logic [1:0]  CPS_RNG_OFF        = 2'h0;

	// 16-bit timer clock source codes
	localparam logic [1:0]  CPS_T16_FOSC4      = 2'h0;
	localparam logic [1:0]  CPS_T16_FOSC       = 2'h1;
	localparam logic [1:0]  CPS_T16_NONE       = 2'h2;
	localparam logic [1:0]  CPS_T16_OSC        = 2'h3;

	// instruction clock is one quarter of the system clock
	localparam logic [1:0]  CPS_DIV4_LAST      = 2'h3;

	// pads
	localparam int          CPS_PADS           = 16;
	localparam logic [3:0]  CPS_SMALL_CH_MASK  = 4'h7;

	// bus
	localparam logic [1:0]  CPS_HRESP_OKAY     = 2'h0;
	localparam logic [2:0]  CPS_HSIZE_WORD     = 3'h2;

endpackage

// >>> rtl/cps_sense_ctrl.sv
// capacitive sensing control: registers, pad select and timer clock routing
// How it works
// - enable bit set runs the sensing unit; clear shuts it down completely.
// - range 00 oscillator off, 01 low, 10 medium, 11 high current.
// - read-only phase bit is 1 while sourcing current, 0 while sinking.
// - with external clock chosen, source bit picks oscillator (1) or clock pin (0).
// - internal clock select makes the 8-bit timer count system clock divided by four.
// - while disabled the channel field is ignored and no pad connects.
// - while enabled channel code n connects pad n, codes 0 to 15.
// - small variant: codes 8 and up select nothing, top bit reads zero.
// - 16-bit timer source code 11 clocks it from the sensing oscillator.
// - 16-bit timer off when not on, free when gate off, gated otherwise.
// - oscillator keeps running in sleep while the enable bit stays set.
// - the 8-bit timer gets no counts during sleep.
// - counts may gather in sleep; evaluation happens only while awake.
// - control bits 6 to 4 read zero and ignore writes.
`timescale 1ns/1ps
module cps_sense_ctrl
	import cps_pkg::*;
#(
	parameter bit SMALL_PKG = 1'b0
) (
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// ahb-lite slave
	input  wire logic                 hsel_in,
	input  wire logic [31:0]          haddr_in,
	input  wire logic [1:0]           htrans_in,
	input  wire logic                 hwrite_in,
	input  wire logic [2:0]           hsize_in,
	input  wire logic [31:0]          hwdata_in,
	input  wire logic                 hready_in,
	output logic      [31:0]          hrdata_out,
	output logic                      hreadyout_out,
	output logic      [1:0]           hresp_out,
	// analogue side and pins
	input  wire logic                 osc_phase_in,
	input  wire logic                 timer8_ext_clock_pin_in,
	input  wire logic                 timer16_gate_in,
	input  wire logic                 sleep_in,
	output logic                      sense_enable_out,
	output logic      [1:0]           osc_range_out,
	output logic      [CPS_PADS-1:0]  sense_pad_n_out,
	// count strobes towards the timers
	output logic                      timer8_count_out,
	output logic                      timer16_count_out
);

	cps_osc_if osc ();

	cps_osc_track u_track (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.osc_phase_in (osc_phase_in),
		.osc          (osc.track)
	);

	// registers
	logic       sense_enable_r, sense_enable_nxt;
	logic [1:0] osc_range_r, osc_range_nxt;
	logic       t8_xs_r, t8_xs_nxt;
	logic [3:0] pad_channel_sel_r, pad_channel_sel_nxt;
	logic       t8_cs_r, t8_cs_nxt;
	logic [1:0] t16_cs_r, t16_cs_nxt;
	logic       t16_on_r, t16_on_nxt;
	logic       t16_ge_r, t16_ge_nxt;

	// bus state
	logic        wr_pend_r, wr_pend_nxt;
	logic [3:0]  wr_off_r, wr_off_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// pin synchronisers
	logic ext_s1_r, ext_s2_r, ext_s3_r, gate_s1_r, gate_s2_r;
	logic ext_s1_nxt, ext_s2_nxt, ext_s3_nxt, gate_s1_nxt, gate_s2_nxt;

	// routing state and outputs
	logic [1:0]          div_r, div_nxt;
	logic                t8_cnt_r, t8_cnt_nxt;
	logic                t16_cnt_r, t16_cnt_nxt;
	logic [CPS_PADS-1:0] pad_r, pad_nxt;
	logic                en_out_r, en_out_nxt;
	logic [1:0]          rng_out_r, rng_out_nxt;

	logic        addr_phase;
	logic        mapped;
	logic [3:0]  chan_eff;
	logic [7:0]  ctrl_rd;
	logic [7:0]  chan_rd;
	logic [7:0]  tcfg_rd;
	logic [7:0]  stat_rd;
	logic        div4_tick;
	logic        ext_rise;
	logic        t8_src;
	logic        t16_src;

	assign osc.enable = sense_enable_r;
	assign osc.range  = osc_range_r;

	always_comb begin
		// small variant drops the top channel bit
		chan_eff = SMALL_PKG ? (pad_channel_sel_r & CPS_SMALL_CH_MASK) : pad_channel_sel_r;
		ctrl_rd  = 8'h00;
		ctrl_rd[CPS_CTRL_EN_BIT]                   = sense_enable_r;
		ctrl_rd[CPS_CTRL_RNG_LSB +: 2]             = osc_range_r;
		ctrl_rd[CPS_CTRL_PHASE_BIT]                = osc.phase;
		ctrl_rd[CPS_CTRL_T8XS_BIT]                 = t8_xs_r;
		chan_rd  = {4'h0, chan_eff};
		tcfg_rd  = 8'h00;
		tcfg_rd[CPS_TCFG_T8CS_BIT]                 = t8_cs_r;
		tcfg_rd[CPS_TCFG_T16CS_LSB +: 2]           = t16_cs_r;
		tcfg_rd[CPS_TCFG_T16ON_BIT]                = t16_on_r;
		tcfg_rd[CPS_TCFG_T16GE_BIT]                = t16_ge_r;
		stat_rd  = 8'h00;
		stat_rd[CPS_STAT_PHASE_BIT]                = osc.phase;
		stat_rd[CPS_STAT_SLEEP_BIT]                = sleep_in;
		stat_rd[CPS_STAT_GATE_BIT]                 = gate_s2_r;
	end

	// bus slave: zero wait states, reads sampled in the address phase
	always_comb begin
		addr_phase  = hsel_in && htrans_in[1] && hready_in;
		mapped      = (haddr_in[31:4] == 28'h0) && (haddr_in[1:0] == 2'h0);
		wr_pend_nxt = addr_phase && hwrite_in && mapped && (hsize_in == CPS_HSIZE_WORD);
		wr_off_nxt  = haddr_in[3:0];
		rdata_nxt   = 32'h0;
		if (addr_phase && !hwrite_in && mapped) begin
			unique case (haddr_in[3:0])
				CPS_OFF_CTRL:   rdata_nxt = {24'h0, ctrl_rd};
				CPS_OFF_CHAN:   rdata_nxt = {24'h0, chan_rd};
				CPS_OFF_TMRCFG: rdata_nxt = {24'h0, tcfg_rd};
				CPS_OFF_STATUS: rdata_nxt = {24'h0, stat_rd};
				default:        rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_pend_r <= 1'b0;
			wr_off_r  <= 4'h0;
			rdata_r   <= 32'h0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_off_r  <= wr_off_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// register writes land in the data phase
	always_comb begin
		sense_enable_nxt    = sense_enable_r;
		osc_range_nxt       = osc_range_r;
		t8_xs_nxt           = t8_xs_r;
		pad_channel_sel_nxt = pad_channel_sel_r;
		t8_cs_nxt           = t8_cs_r;
		t16_cs_nxt          = t16_cs_r;
		t16_on_nxt          = t16_on_r;
		t16_ge_nxt          = t16_ge_r;
		if (wr_pend_r) begin
			unique case (wr_off_r)
				CPS_OFF_CTRL: begin
					// bits 6..4 and the phase bit are not stored
					sense_enable_nxt = hwdata_in[CPS_CTRL_EN_BIT];
					osc_range_nxt    = hwdata_in[CPS_CTRL_RNG_LSB +: 2];
					t8_xs_nxt        = hwdata_in[CPS_CTRL_T8XS_BIT];
				end
				CPS_OFF_CHAN: begin
					pad_channel_sel_nxt = hwdata_in[3:0];
				end
				CPS_OFF_TMRCFG: begin
					t8_cs_nxt  = hwdata_in[CPS_TCFG_T8CS_BIT];
					t16_cs_nxt = hwdata_in[CPS_TCFG_T16CS_LSB +: 2];
					t16_on_nxt = hwdata_in[CPS_TCFG_T16ON_BIT];
					t16_ge_nxt = hwdata_in[CPS_TCFG_T16GE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sense_enable_r    <= CPS_CTRL_RST[CPS_CTRL_EN_BIT];
			osc_range_r       <= CPS_CTRL_RST[CPS_CTRL_RNG_LSB +: 2];
			t8_xs_r           <= CPS_CTRL_RST[CPS_CTRL_T8XS_BIT];
			pad_channel_sel_r <= CPS_CHAN_RST;
			t8_cs_r           <= CPS_TCFG_RST[CPS_TCFG_T8CS_BIT];
			t16_cs_r          <= CPS_TCFG_RST[CPS_TCFG_T16CS_LSB +: 2];
			t16_on_r          <= CPS_TCFG_RST[CPS_TCFG_T16ON_BIT];
			t16_ge_r          <= CPS_TCFG_RST[CPS_TCFG_T16GE_BIT];
		end else begin
			sense_enable_r    <= sense_enable_nxt;
			osc_range_r       <= osc_range_nxt;
			t8_xs_r           <= t8_xs_nxt;
			pad_channel_sel_r <= pad_channel_sel_nxt;
			t8_cs_r           <= t8_cs_nxt;
			t16_cs_r          <= t16_cs_nxt;
			t16_on_r          <= t16_on_nxt;
			t16_ge_r          <= t16_ge_nxt;
		end
	end

	// pad mux, analogue enables and timer clock routing
	always_comb begin
		ext_s1_nxt  = timer8_ext_clock_pin_in;
		ext_s2_nxt  = ext_s1_r;
		ext_s3_nxt  = ext_s2_r;
		gate_s1_nxt = timer16_gate_in;
		gate_s2_nxt = gate_s1_r;
		div_nxt     = div_r + 2'h1;
		div4_tick   = (div_r == CPS_DIV4_LAST);
		ext_rise    = ext_s2_r && !ext_s3_r;
		// sleep leaves enable and range alone so the oscillator keeps running
		en_out_nxt  = sense_enable_r;
		rng_out_nxt = sense_enable_r ? osc_range_r : CPS_RNG_OFF;
		pad_nxt     = '0;
		if (sense_enable_r && !(SMALL_PKG && pad_channel_sel_r[3])) begin
			pad_nxt[pad_channel_sel_r] = 1'b1;
		end
		if (t8_cs_r) begin
			t8_src = t8_xs_r ? osc.tick : ext_rise;
		end else begin
			t8_src = div4_tick;
		end
		t8_cnt_nxt = t8_src && !sleep_in;
		unique case (t16_cs_r)
			CPS_T16_OSC:   t16_src = osc.tick;
			CPS_T16_FOSC4: t16_src = div4_tick;
			CPS_T16_FOSC:  t16_src = 1'b1;
			CPS_T16_NONE:  t16_src = 1'b0;
		endcase
		// counts keep flowing in sleep; software reads them once awake
		t16_cnt_nxt = t16_on_r && (!t16_ge_r || gate_s2_r) && t16_src;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ext_s1_r  <= 1'b0;
			ext_s2_r  <= 1'b0;
			ext_s3_r  <= 1'b0;
			gate_s1_r <= 1'b0;
			gate_s2_r <= 1'b0;
			div_r     <= 2'h0;
			t8_cnt_r  <= 1'b0;
			t16_cnt_r <= 1'b0;
			pad_r     <= '0;
			en_out_r  <= 1'b0;
			rng_out_r <= CPS_RNG_OFF;
		end else begin
			ext_s1_r  <= ext_s1_nxt;
			ext_s2_r  <= ext_s2_nxt;
			ext_s3_r  <= ext_s3_nxt;
			gate_s1_r <= gate_s1_nxt;
			gate_s2_r <= gate_s2_nxt;
			div_r     <= div_nxt;
			t8_cnt_r  <= t8_cnt_nxt;
			t16_cnt_r <= t16_cnt_nxt;
			pad_r     <= pad_nxt;
			en_out_r  <= en_out_nxt;
			rng_out_r <= rng_out_nxt;
		end
	end

	assign hrdata_out        = rdata_r;
	assign hreadyout_out     = 1'b1;
	assign hresp_out         = CPS_HRESP_OKAY;
	assign sense_enable_out  = en_out_r;
	assign osc_range_out     = rng_out_r;
	assign sense_pad_n_out   = pad_r;
	assign timer8_count_out  = t8_cnt_r;
	assign timer16_count_out = t16_cnt_r;

	// checks
	pad_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!sense_enable_r |=> sense_pad_n_out == '0)
		else $error("pad connected while disabled");

	pad_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(sense_enable_r && !SMALL_PKG) |=> sense_pad_n_out == (16'h0001 << $past(pad_channel_sel_r)))
		else $error("wrong pad selected");

	small_pad_a: assert property (@(posedge clk_in) disable iff (rst_in)
		SMALL_PKG |-> sense_pad_n_out[15:8] == 8'h00)
		else $error("unimplemented pad selected");

	range_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
		##1 osc_range_out == ($past(sense_enable_r) ? $past(osc_range_r) : CPS_RNG_OFF))
		else $error("range output does not follow register");

	t8_int_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!t8_cs_r |=> timer8_count_out == ($past(div_r) == 2'h3 && !$past(sleep_in)))
		else $error("8-bit timer not on quarter clock");

	t8_osc_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(t8_cs_r && t8_xs_r && !sleep_in) |=> timer8_count_out == $past(osc.tick))
		else $error("8-bit timer not fed by oscillator");

	t8_sleep_a: assert property (@(posedge clk_in) disable iff (rst_in)
		sleep_in |=> !timer8_count_out)
		else $error("8-bit timer counted in sleep");

	t16_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(!t16_on_r || (t16_ge_r && !gate_s2_r)) |=> !timer16_count_out)
		else $error("16-bit timer counted while off or gated");

	t16_osc_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(t16_on_r && !t16_ge_r && t16_cs_r == CPS_T16_OSC) |=> timer16_count_out == $past(osc.tick))
		else $error("16-bit timer not fed by oscillator");

	ctrl_rsvd_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(addr_phase && !hwrite_in && haddr_in == 32'h0) |=> hrdata_out[6:4] == 3'h0)
		else $error("unused control bits read nonzero");

	sleep_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(sleep_in && sense_enable_r) |=> sense_enable_out)
		else $error("oscillator stopped in sleep");

	cov_pad_c:   cover property (@(posedge clk_in) disable iff (rst_in) sense_pad_n_out[15]);
	cov_t8osc_c: cover property (@(posedge clk_in) disable iff (rst_in) t8_cs_r && t8_xs_r && timer8_count_out);
	cov_t16g_c:  cover property (@(posedge clk_in) disable iff (rst_in) t16_ge_r && timer16_count_out);
	cov_slp_c:   cover property (@(posedge clk_in) disable iff (rst_in) sleep_in && timer16_count_out);

endmodule // cps_sense_ctrl
